// ===== rtl/sync_serial_spi_port.sv
// byte-wide spi port, master or slave, with receive buffer and flags
`timescale 1ns/1ps
`include "spi_port_cfg.svh"

// Summary of operation
// - master starts shifting on buffer write
// - master samples input even without output
// - master rate from five selectable sources
// - polarity bit sets sck idle level, edge bit picks data edge
// - sample phase picks middle or end
// - slave shifts on sck, flags eighth bit
// - slave keeps receiving during sleep, wakes
// - sleep freezes master transfer, then resumes
// - overwrite enable accepts writes when full
// - select control only in mode 0100
// - select low enables shifting, drives output
// - select high floats output immediately
// - select high or disable clears bit counter
// - eight-bit register, msb out, lsb in
// - write while shifting dropped, collision flagged
// - received byte sets full; read clears
module sync_serial_spi_port
  import spi_port_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic port_enable,
  input wire logic [3:0] mode_select,
  input wire logic clock_idle_polarity,
  input wire logic clock_edge,
  input wire logic input_sample_phase,
  input wire logic buffer_overwrite_enable,
  input wire logic [7:0] rate_reload_value,
  input wire logic timer_two_tick,
  input wire logic sleep_mode,
  input wire logic buffer_write,
  input wire logic [7:0] buffer_write_data,
  input wire logic buffer_read,
  input wire logic complete_flag_clear,
  input wire logic collision_flag_clear,
  input wire logic sck_in,
  input wire logic sdi_in,
  input wire logic select_n_in,
  output logic sck_out,
  output logic sck_oe,
  output logic sdo_out,
  output logic sdo_oe,
  output logic [7:0] transfer_buffer,
  output logic buffer_full_flag,
  output logic write_collision_flag,
  output logic transfer_complete_flag,
  output logic wake_request,
  output logic busy,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready
);
  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function automatic logic is_master(input logic [3:0] m);
    return (m == `MODE_MASTER_DIV4) || (m == `MODE_MASTER_DIV16) ||
           (m == `MODE_MASTER_DIV64) || (m == `MODE_MASTER_TIMER) ||
           (m == `MODE_MASTER_RELOAD);
  endfunction

  function automatic logic [9:0] half_len(input logic [3:0] m, input logic [7:0] r);
    unique case (m)
      `MODE_MASTER_DIV16: return `HALF_DIV16;
      `MODE_MASTER_DIV64: return `HALF_DIV64;
      `MODE_MASTER_RELOAD: return 10'(({2'b00, r} + 10'h001) << 1);
      default: return `HALF_DIV4;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers: sck, sdi, select
  // ---------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] sy1;
  logic [2:0] sy2;
  logic [2:0] sy3;
  logic [2:0] lvl;
  logic [2:0] next_lvl;
  logic sck_edge;

  assign pin_raw = {select_n_in, sdi_in, sck_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      // a level only counts once the second and third stages agree
      always_comb begin
        next_lvl[gi] = (sy2[gi] == sy3[gi]) ? sy3[gi] : lvl[gi];
      end
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          sy1[gi] <= 1'b1;
          sy2[gi] <= 1'b1;
          sy3[gi] <= 1'b1;
          lvl[gi] <= 1'b1;
        end else begin
          sy1[gi] <= pin_raw[gi];
          sy2[gi] <= sy1[gi];
          sy3[gi] <= sy2[gi];
          lvl[gi] <= next_lvl[gi];
        end
      end
    end
  endgenerate

  assign sck_edge = next_lvl[0] != lvl[0];

  // ---------------------------------------------------------------
  // mode decode and write qualification
  // ---------------------------------------------------------------
  master_state_t state;
  master_state_t next_state;
  logic [7:0] shreg;
  logic [9:0] div_cnt;
  logic [4:0] half_cnt;
  logic [3:0] bit_cnt;
  logic push_valid;
  logic [7:0] push_data;
  logic push_ready;
  logic master_on;
  logic slave_on;
  logic select_mode;
  logic slave_held;
  logic write_ok;
  logic complete;
  logic [7:0] next_shreg;
  logic [9:0] next_div_cnt;
  logic [4:0] next_half_cnt;
  logic [3:0] next_bit_cnt;
  logic next_sck_out;
  logic next_sdo_out;
  logic half_tick;
  logic [4:0] kn;
  logic [4:0] off;
  logic sample_now;
  logic change_now;
  logic lead_edge;

  assign master_on = port_enable && is_master(mode_select);
  assign slave_on = port_enable && !is_master(mode_select);
  assign select_mode = mode_select == `MODE_SLAVE_SELECT;
  assign slave_held = select_mode && lvl[2];
  assign write_ok = buffer_write && port_enable && !busy && !write_collision_flag &&
                    (!buffer_full_flag || buffer_overwrite_enable) && push_ready;

  assign half_tick = (mode_select == `MODE_MASTER_TIMER) ? timer_two_tick :
                     (div_cnt == 10'(half_len(mode_select, rate_reload_value) - 10'h001));
  assign kn = half_cnt + 5'h01;
  assign off = (clock_edge ? 5'h01 : 5'h02) + {4'h0, input_sample_phase};
  assign lead_edge = next_lvl[0] != clock_idle_polarity;

  // ---------------------------------------------------------------
  // shift engine
  // ---------------------------------------------------------------
  // no config latch
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_div_cnt = div_cnt;
    next_half_cnt = half_cnt;
    next_bit_cnt = bit_cnt;
    next_sck_out = sck_out;
    next_sdo_out = sdo_out;
    complete = 1'b0;
    sample_now = 1'b0;
    change_now = 1'b0;
    if (write_ok) begin
      next_shreg = buffer_write_data;
      next_sdo_out = buffer_write_data[7];
    end
    if (master_on) begin
      if (state == M_IDLE && write_ok) begin
        next_state = M_SHIFT;
        next_div_cnt = `RST_DIV;
        next_half_cnt = `RST_HALF;
        next_bit_cnt = `RST_BITS;
      end
      if (state == M_SHIFT && !sleep_mode) begin
        next_div_cnt = half_tick ? `RST_DIV : div_cnt + 10'h001;
        if (half_tick) begin
          next_half_cnt = kn;
          if (kn <= `LAST_TOGGLE) begin
            next_sck_out = !sck_out;
          end
          sample_now = (kn >= off) && (kn[0] == off[0]);
          change_now = clock_edge ?
            (!kn[0] && kn >= `FIRST_CHANGE_LEAD && kn <= `LAST_CHANGE_LEAD) :
            (kn[0] && kn >= `FIRST_CHANGE_TRAIL && kn <= `LAST_CHANGE_TRAIL);
          if (sample_now) begin
            next_shreg = {shreg[6:0], lvl[1]};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          if (change_now) begin
            next_sdo_out = sample_now ? shreg[6] : shreg[7];
          end
          if (sample_now && bit_cnt == `BITS_PER_BYTE - 4'h1) begin
            complete = 1'b1;
            next_bit_cnt = `RST_BITS;
          end
          // a mid-bit final sample still owes the last trailing edge
          if (kn >= `LAST_TOGGLE && next_bit_cnt == `RST_BITS) begin
            next_state = M_IDLE;
          end
        end
      end
      if (next_state == M_IDLE) begin
        next_sck_out = clock_idle_polarity;
      end
    end else begin
      next_state = M_IDLE;
      next_sck_out = clock_idle_polarity;
      if (!slave_on || slave_held) begin
        next_bit_cnt = `RST_BITS;
      end else if (sck_edge) begin
        if (lead_edge == clock_edge) begin
          next_shreg = {shreg[6:0], lvl[1]};
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == `BITS_PER_BYTE - 4'h1) begin
            complete = 1'b1;
            next_bit_cnt = `RST_BITS;
          end
        end else begin
          next_sdo_out = shreg[7];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= M_IDLE;
      shreg <= `RST_BYTE;
      div_cnt <= `RST_DIV;
      half_cnt <= `RST_HALF;
      bit_cnt <= `RST_BITS;
      sck_out <= 1'b0;
      sdo_out <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      div_cnt <= next_div_cnt;
      half_cnt <= next_half_cnt;
      bit_cnt <= next_bit_cnt;
      sck_out <= next_sck_out;
      sdo_out <= next_sdo_out;
    end
  end

  // ---------------------------------------------------------------
  // flags, buffer and pin enables
  // ---------------------------------------------------------------
  logic [7:0] next_transfer_buffer;
  logic next_bf;
  logic next_write_collision_flag;
  logic next_tcf;
  logic next_wake;
  logic next_busy;
  logic next_sdo_oe;

  always_comb begin
    next_transfer_buffer = transfer_buffer;
    if (write_ok) begin
      next_transfer_buffer = buffer_write_data;
    end
    if (complete) begin
      next_transfer_buffer = next_shreg;
    end
    next_bf = complete || (buffer_full_flag && !buffer_read);
    next_write_collision_flag = (buffer_write && port_enable && busy) ||
                (write_collision_flag && !collision_flag_clear);
    next_tcf = complete || (transfer_complete_flag && !complete_flag_clear);
    next_wake = complete && sleep_mode && slave_on;
    next_busy = (next_state == M_SHIFT) || (slave_on && next_bit_cnt != `RST_BITS);
    next_sdo_oe = master_on || (slave_on && !(select_mode && next_lvl[2]));
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      transfer_buffer <= `RST_BYTE;
      buffer_full_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      transfer_complete_flag <= 1'b0;
      wake_request <= 1'b0;
      busy <= 1'b0;
      sdo_oe <= 1'b0;
      sck_oe <= 1'b0;
      push_valid <= 1'b0;
      push_data <= `RST_BYTE;
    end else begin
      transfer_buffer <= next_transfer_buffer;
      buffer_full_flag <= next_bf;
      write_collision_flag <= next_write_collision_flag;
      transfer_complete_flag <= next_tcf;
      wake_request <= next_wake;
      busy <= next_busy;
      sdo_oe <= next_sdo_oe;
      sck_oe <= master_on;
      push_valid <= complete;
      push_data <= next_shreg;
    end
  end

  // a slave byte arriving while both entries are full is dropped
  pair_buffer #(.WIDTH(8)) u_rx_buffer (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(push_valid),
    .in_data(push_data),
    .in_ready(push_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_start_on_write;
    master_on && state == M_IDLE && write_ok |=> state == M_SHIFT && busy;
  endproperty
  a_start_on_write: assert property (p_start_on_write) else $error("no start");

  property p_msb_first;
    write_ok |=> sdo_out == $past(buffer_write_data[7]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("msb not first");

  property p_collision;
    buffer_write && port_enable && busy && !complete |=>
      write_collision_flag && $stable(transfer_buffer);
  endproperty
  a_collision: assert property (p_collision) else $error("collision missed");

  property p_full_on_complete;
    complete |=> buffer_full_flag && transfer_complete_flag ##1 push_valid == 1'b0;
  endproperty
  a_full_on_complete: assert property (p_full_on_complete) else $error("flags not set");

  property p_select_float;
    slave_on && select_mode && lvl[2] && sy3[2] |=> !sdo_oe && bit_cnt == `RST_BITS;
  endproperty
  a_select_float: assert property (p_select_float) else $error("sdo still driven");

  property p_select_drive;
    slave_on && select_mode && !next_lvl[2] |=> sdo_oe;
  endproperty
  a_select_drive: assert property (p_select_drive) else $error("sdo not driven");

  property p_disable_clears;
    !port_enable |=> bit_cnt == `RST_BITS && !busy;
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("count kept");

  property p_sleep_freeze;
    master_on && state == M_SHIFT && sleep_mode |=> $stable(half_cnt) && $stable(sck_out);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze) else $error("moved in sleep");

  property p_idle_sck;
    master_on && state == M_IDLE && $stable(clock_idle_polarity) [*2] |-> sck_out == clock_idle_polarity;
  endproperty
  a_idle_sck: assert property (p_idle_sck) else $error("sck not idle");

  property p_div4_rate;
    master_on && mode_select == `MODE_MASTER_DIV4 && state == M_SHIFT && !sleep_mode &&
    half_tick && kn < `LAST_TOGGLE ##1 $stable(mode_select) && !sleep_mode
    |-> ##1 $stable(sck_out) ##1 sck_out != $past(sck_out);
  endproperty
  a_div4_rate: assert property (p_div4_rate) else $error("bad fosc/4 rate");

  c_master_byte: cover property (master_on && complete);
  c_slave_byte: cover property (slave_on && complete);
  c_collision: cover property (buffer_write && busy && port_enable);
  c_select_abort: cover property (slave_on && select_mode && busy ##1 lvl[2]);
endmodule // sync_serial_spi_port

// ===== rtl/spi_port_cfg.svh
// constants for the synchronous serial port: mode codes, rates, reset values
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

// four-bit mode field encodings
`define MODE_MASTER_DIV4 4'h0
`define MODE_MASTER_DIV16 4'h1
`define MODE_MASTER_DIV64 4'h2
`define MODE_MASTER_TIMER 4'h3
`define MODE_SLAVE_SELECT 4'h4
`define MODE_SLAVE_FREE 4'h5
`define MODE_MASTER_RELOAD 4'ha

// half sck periods in system clocks (fosc/4, fosc/16, fosc/64)
`define HALF_DIV4 10'h002
`define HALF_DIV16 10'h008
`define HALF_DIV64 10'h020

// shift sequencing
`define BITS_PER_BYTE 4'h8
`define LAST_TOGGLE 5'h10
`define FIRST_CHANGE_LEAD 5'h02
`define LAST_CHANGE_LEAD 5'h0e
`define FIRST_CHANGE_TRAIL 5'h03
`define LAST_CHANGE_TRAIL 5'h0f

// reset values
`define RST_BYTE 8'h00
`define RST_DIV 10'h000
`define RST_HALF 5'h00
`define RST_BITS 4'h0

`endif

// ===== rtl/spi_port_pkg.sv
// types shared by the synchronous serial port
package spi_port_pkg;
  typedef enum logic [1:0] {
    M_IDLE  = 2'b01,
    M_SHIFT = 2'b10
  } master_state_t;
endpackage

// ===== rtl/pair_buffer.sv
// two-entry valid/ready buffer for received bytes
`timescale 1ns/1ps
module pair_buffer #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic spare_valid;
  logic [WIDTH-1:0] spare_data;
  logic next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic next_spare_valid;
  logic [WIDTH-1:0] next_spare_data;
  logic push;
  logic pop;

  // in_ready is just the spare slot being free, so it stays a flop
  assign in_ready = !spare_valid;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_out_valid = out_valid;
    next_out_data = out_data;
    next_spare_valid = spare_valid;
    next_spare_data = spare_data;
    if (pop || !out_valid) begin
      if (spare_valid) begin
        next_out_valid = 1'b1;
        next_out_data = spare_data;
        next_spare_valid = push;
        if (push) begin
          next_spare_data = in_data;
        end
      end else begin
        next_out_valid = push;
        if (push) begin
          next_out_data = in_data;
        end
      end
    end else if (push) begin
      next_spare_valid = 1'b1;
      next_spare_data = in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
      spare_valid <= 1'b0;
      spare_data <= '0;
    end else begin
      out_valid <= next_out_valid;
      out_data <= next_out_data;
      spare_valid <= next_spare_valid;
      spare_data <= next_spare_data;
    end
  end
endmodule // pair_buffer

// ===== sim/spi_far_end.sv
// far-end spi device: byte responder to our master, frame master to our slave
`timescale 1ns/1ps
module spi_far_end (
  input wire logic clk,
  input wire logic cpol,
  input wire logic cke,
  input wire logic dut_sck,
  input wire logic dut_sck_oe,
  input wire logic dut_sdo,
  input wire logic dut_sdo_oe,
  output logic sck_pin,
  output logic sdi_pin,
  output logic sel_n
);
  logic [7:0] reply = 8'h00;
  logic [7:0] cap = 8'h00;
  logic armed = 1'b0;
  logic framing = 1'b0;
  logic sck_q = 1'b0;
  int edges = 0;
  int undriven = 0;

  initial begin
    sck_pin = 1'b0;
    sdi_pin = 1'b0;
    sel_n = 1'b1;
  end

  // --------------------------------
  // responder to a master port
  // --------------------------------
  always @(posedge clk) begin
    sck_q <= dut_sck;
    if (!framing) sck_pin <= cpol;
    // released line keeps moving so stale bits cannot pass
    if (!framing && !armed) sdi_pin <= ~sdi_pin;
    if (armed && dut_sck_oe && dut_sck !== sck_q) begin
      edges = edges + 1;
      if ((edges % 2 == 1) == cke) cap = {cap[6:0], dut_sdo};
      else if (edges > 1 && edges < 16) begin
        reply = reply << 1;
        sdi_pin <= reply[7];
      end
    end
  end

  task arm(input logic [7:0] b);
    reply = b;
    cap = 8'h00;
    edges = 0;
    armed = 1'b1;
    sdi_pin <= b[7];
  endtask

  // --------------------------------
  // master frame toward a slave port
  // --------------------------------
  task automatic frame(input logic [7:0] b, input int nbits, input int half);
    logic [7:0] sh;
    sh = b;
    cap = 8'h00;
    framing = 1'b1;
    sel_n <= 1'b0;
    sdi_pin <= sh[7];
    repeat (half) @(posedge clk);
    for (int e = 1; e <= 2 * nbits; e++) begin
      sck_pin <= ~sck_pin;
      if ((e % 2 == 1) == cke) begin
        cap = {cap[6:0], dut_sdo};
        if (!dut_sdo_oe) undriven++;
      end else if (e > 1 && e < 16) begin
        sh = sh << 1;
        sdi_pin <= sh[7];
      end
      repeat (half) @(posedge clk);
    end
    sel_n <= 1'b1;
    framing = 1'b0;
  endtask
endmodule // spi_far_end

// ===== sim/tb_top.sv
// self-checking bench for the spi port against the far-end model
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, sys_rst = 1'b1, port_enable = 1'b0;
  logic [3:0] mode_select = 4'h0;
  logic clock_idle_polarity = 1'b0, clock_edge = 1'b1, input_sample_phase = 1'b0;
  logic buffer_overwrite_enable = 1'b0, timer_two_tick = 1'b0, sleep_mode = 1'b0;
  logic [7:0] rate_reload_value = 8'h03, buffer_write_data = 8'h00;
  logic buffer_write = 1'b0, buffer_read = 1'b0, rx_ready = 1'b1;
  logic complete_flag_clear = 1'b0, collision_flag_clear = 1'b0;
  logic sck_in, sdi_in, select_n_in, far_sck, sck_q = 1'b0;
  logic sck_out, sck_oe, sdo_out, sdo_oe, buffer_full_flag, write_collision_flag;
  logic transfer_complete_flag, wake_request, busy, rx_valid;
  logic [7:0] transfer_buffer, rx_data;
  logic [7:0] rxq [$];
  int n_mismatch = 0, checked = 0, cyc = 0, last = 0, gap = 0, tog = 0, wakes = 0, tcnt = 0;

  assign sck_in = sck_oe ? sck_out : far_sck;
  always #5 clk = ~clk;

  sync_serial_spi_port dut (.clk, .sys_rst, .port_enable, .mode_select,
    .clock_idle_polarity, .clock_edge, .input_sample_phase, .buffer_overwrite_enable,
    .rate_reload_value, .timer_two_tick, .sleep_mode, .buffer_write, .buffer_write_data,
    .buffer_read, .complete_flag_clear, .collision_flag_clear, .sck_in, .sdi_in,
    .select_n_in, .sck_out, .sck_oe, .sdo_out, .sdo_oe, .transfer_buffer,
    .buffer_full_flag, .write_collision_flag, .transfer_complete_flag, .wake_request,
    .busy, .rx_valid, .rx_data, .rx_ready);

  spi_far_end far (.clk(clk), .cpol(clock_idle_polarity), .cke(clock_edge),
    .dut_sck(sck_out), .dut_sck_oe(sck_oe), .dut_sdo(sdo_out), .dut_sdo_oe(sdo_oe),
    .sck_pin(far_sck), .sdi_pin(sdi_in), .sel_n(select_n_in));

  // --------------------------------
  // monitors and timer source
  // --------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sck_q <= sck_out;
    if (sck_out !== sck_q && sck_oe === 1'b1) begin
      tog <= tog + 1;
      gap <= cyc - last;
      last <= cyc;
    end
    if (wake_request === 1'b1) wakes <= wakes + 1;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
    tcnt <= (tcnt == 5) ? 0 : tcnt + 1;
    timer_two_tick <= (tcnt == 5);
  end

  // --------------------------------
  // shared tasks
  // --------------------------------
  task chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task cfg(input logic [3:0] m, input logic p, input logic e, input logic s, input logic o);
    @(posedge clk);
    port_enable <= 1'b0;
    mode_select <= m;
    clock_idle_polarity <= p;
    clock_edge <= e;
    input_sample_phase <= s;
    buffer_overwrite_enable <= o;
    repeat (8) @(posedge clk);
    port_enable <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task wr(input logic [7:0] b);
    @(posedge clk);
    buffer_write <= 1'b1;
    buffer_write_data <= b;
    @(posedge clk);
    buffer_write <= 1'b0;
  endtask

  task ack();
    @(posedge clk);
    buffer_read <= 1'b1;
    complete_flag_clear <= 1'b1;
    collision_flag_clear <= 1'b1;
    @(posedge clk);
    buffer_read <= 1'b0;
    complete_flag_clear <= 1'b0;
    collision_flag_clear <= 1'b0;
  endtask

  task wdone();
    int k;
    k = 0;
    @(negedge clk);
    while (busy !== 1'b0 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    chk(k < 3000, "busy stuck");
    repeat (3) @(negedge clk);
  endtask

  task close_out();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task t_rates();
    logic [3:0] md [5] = '{4'h0, 4'h1, 4'h2, 4'ha, 4'h3};
    int hx [5] = '{2, 8, 32, 8, 6};
    for (int i = 0; i < 5; i++) begin
      cfg(md[i], i[0], 1'b1, 1'b0, 1'b0);
      tog = 0;
      wr(8'h81);
      wdone();
      chk(tog === 16 && gap === hx[i], "sck rate or count");
      chk(sck_out === i[0] && sck_oe === 1'b1, "sck idle level");
      ack();
    end
    $display("test rates done");
  endtask

  task t_data();
    for (int i = 0; i < 4; i++) begin
      cfg(4'h1, i[0], i[1], i[1], 1'b0);
      far.arm(8'h3c);
      rxq.delete();
      tog = 0;
      wr(8'ha5);
      @(negedge clk);
      chk(busy === 1'b1 && sdo_out === 1'b1 && tog === 0, "start");
      repeat (10) @(posedge clk);
      wr(8'h11);
      wdone();
      chk(far.cap === 8'ha5, "bits out");
      chk(transfer_buffer === 8'h3c && rxq.size() == 1, "bits in");
      chk(rxq.size() == 1 && rxq[0] === 8'h3c, "stream byte");
      chk(buffer_full_flag === 1'b1 && transfer_complete_flag === 1'b1, "flags");
      chk(write_collision_flag === 1'b1, "collision");
      ack();
      @(negedge clk);
      chk(buffer_full_flag === 1'b0 && write_collision_flag === 1'b0, "cleared");
      far.armed = 1'b0;
    end
    $display("test data done");
  endtask

  task t_fill();
    cfg(4'h1, 1'b0, 1'b1, 1'b0, 1'b0);
    rx_ready <= 1'b0;
    rxq.delete();
    far.arm(8'h21);
    wr(8'hf0);
    wdone();
    wr(8'hf1);
    @(negedge clk);
    chk(busy === 1'b0, "write while full");
    cfg(4'h1, 1'b0, 1'b1, 1'b0, 1'b1);
    far.arm(8'h23);
    wr(8'hf2);
    @(negedge clk);
    chk(busy === 1'b1, "overwrite write");
    wdone();
    wr(8'hf3);
    @(negedge clk);
    chk(busy === 1'b0 && rx_valid === 1'b1, "rx back-pressure");
    rx_ready <= 1'b1;
    repeat (6) @(negedge clk);
    chk(rxq.size() == 2 && rxq[0] === 8'h21 && rxq[1] === 8'h23, "drain order");
    ack();
    $display("test fill done");
  endtask

  task t_sleep();
    int t0;
    cfg(4'h1, 1'b0, 1'b1, 1'b0, 1'b0);
    far.arm(8'h6d);
    tog = 0;
    wr(8'hc3);
    for (int k = 0; k < 300 && tog < 6; k++) @(negedge clk);
    @(posedge clk);
    sleep_mode <= 1'b1;
    repeat (3) @(negedge clk);
    t0 = tog;
    repeat (40) @(negedge clk);
    chk(tog == t0 && busy === 1'b1, "frozen in sleep");
    @(posedge clk);
    sleep_mode <= 1'b0;
    wdone();
    chk(far.cap === 8'hc3 && transfer_buffer === 8'h6d, "resumed");
    ack();
    far.armed = 1'b0;
    $display("test sleep done");
  endtask

  task t_slave();
    // edge bit set only with select control, sample phase kept clear
    cfg(4'h4, 1'b0, 1'b1, 1'b0, 1'b0);
    wr(8'h5a);
    sleep_mode <= 1'b1;
    wakes = 0;
    far.frame(8'h96, 8, 8);
    repeat (8) @(negedge clk);
    chk(far.cap === 8'h5a && far.undriven == 0, "slave out");
    chk(transfer_buffer === 8'h96 && transfer_complete_flag === 1'b1, "slave in");
    chk(wakes > 0, "wake");
    sleep_mode <= 1'b0;
    ack();
    wr(8'h0f);
    far.frame(8'hff, 4, 8);
    repeat (6) @(negedge clk);
    chk(sdo_oe === 1'b0 && busy === 1'b0, "select high");
    far.frame(8'h3c, 8, 8);
    repeat (8) @(negedge clk);
    chk(transfer_buffer === 8'h3c, "realigned");
    ack();
    cfg(4'h5, 1'b1, 1'b0, 1'b0, 1'b0);
    far.frame(8'he1, 3, 8);
    cfg(4'h5, 1'b1, 1'b0, 1'b0, 1'b0);
    far.frame(8'h78, 8, 8);
    repeat (8) @(negedge clk);
    chk(transfer_buffer === 8'h78, "enable reset");
    $display("test slave done");
  endtask

  initial begin
    #400000;
    n_mismatch++;
    $display("BAD %0t timeout", $time);
    close_out();
  end

  initial begin
    repeat (20) @(posedge clk);
    chk(busy === 1'b0 && sck_oe === 1'b0 && buffer_full_flag === 1'b0, "reset");
    sys_rst <= 1'b0;
    t_rates();
    t_data();
    t_fill();
    t_sleep();
    t_slave();
    close_out();
  end
endmodule // tb_top
